// File: lcd_cfg.svh
// command codes, field positions, reset values and sizes of the command decoder
`ifndef LCD_CFG_SVH
`define LCD_CFG_SVH

// command bytes
`define CMD_SYSTEM_SET   8'h40
`define CMD_MEM_WRITE    8'h42
`define CMD_MEM_READ     8'h43
`define CMD_SCROLL       8'h44
`define CMD_CURSOR_WRITE 8'h46
`define CMD_CURSOR_READ  8'h47
`define CMD_CURSOR_RIGHT 8'h4c
`define CMD_CURSOR_LEFT  8'h4d
`define CMD_CURSOR_UP    8'h4e
`define CMD_CURSOR_DOWN  8'h4f
`define CMD_ERASE        8'h52
`define CMD_SLEEP        8'h53
`define CMD_DISPLAY_OFF  8'h58
`define CMD_DISPLAY_ON   8'h59
`define CMD_DOT_SCROLL   8'h5a
`define CMD_OVERLAY      8'h5b
`define CMD_CHARGEN_ADDR 8'h5c

// status byte bit positions
`define STAT_BUSY_BIT    6
`define STAT_SLEEP_BIT   0

// display memory size and last address
`define MEM_DEPTH        32768
`define MEM_TOP          16'h7fff

// data path fifo shape
`define FIFO_WIDTH       9
`define FIFO_DEPTH       16

// reset values
`define RST_CMD          8'h00
`define RST_CURSOR       16'h0000
`define RST_LAYER_ATTR   8'h00
`define RST_OVERLAY      8'h00
`define RST_ADDR         16'h0000
`define RST_LINES        8'h00
`define RST_DOT_SCROLL   3'h0

`endif

// File: lcd_pkg.sv
// types shared by the command decoder and its testbench
`default_nettype none
package lcd_pkg;

  // decoder activity
  typedef enum logic [1:0] {ST_RUN, ST_ERASE, ST_SLEEP} dec_state_e;

  // one host write as it travels through the fifo
  typedef struct packed {
    logic       is_cmd;
    logic [7:0] val;
  } host_byte_s;

  // overlay parameter layout
  typedef struct packed {
    logic [2:0] zero_bits;
    logic       layer_count_select;
    logic       third_layer_kind;
    logic       first_layer_kind;
    logic       combine_method_hi;
    logic       combine_method_lo;
  } overlay_s;

  // layer start addresses and line counts
  typedef struct packed {
    logic [15:0] layer_one_start;
    logic [7:0]  layer_one_lines;
    logic [15:0] layer_two_start;
    logic [7:0]  layer_two_lines;
    logic [15:0] layer_three_start;
  } scroll_s;

endpackage
`default_nettype wire

// File: byte_fifo.sv
// first-in first-out buffer with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rstn,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output wire logic             in_ready,
  // drain side
  output wire logic             out_valid,
  output wire logic [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
  } fifo_state_s;

  fifo_state_s      r;
  fifo_state_s      n;
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic             empty;
  logic             full;
  logic             do_push;
  logic             do_pop;

  // full when pointers differ only in the wrap bit
  assign empty     = (r.wr_ptr == r.rd_ptr);
  assign full      = (r.wr_ptr[AW] != r.rd_ptr[AW]) && (r.wr_ptr[AW-1:0] == r.rd_ptr[AW-1:0]);
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign out_data  = mem[r.rd_ptr[AW-1:0]];
  assign do_push   = in_valid & ~full;
  assign do_pop    = out_ready & ~empty;

  // pointer update
  always_comb begin
    n = r;
    if (do_push) begin
      n.wr_ptr = r.wr_ptr + 1'b1;
    end
    if (do_pop) begin
      n.rd_ptr = r.rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // storage
  always_ff @(posedge mclk) begin
    if (do_push) begin
      mem[r.wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule
`default_nettype wire

// File: lcd_graphic_command_decoder.sv
// host command decoder of a layered graphic and text display controller
// Functional notes
// - display off blanks layers, takes attribute byte
// - overlay low two bits choose combine method
// - overlay bits set layer kinds, layer count
// - chargen base: low byte then high byte
// - scroll takes eight parameters in fixed order
// - dot scroll keeps three low bits
// - codes 4ch to 4fh pick cursor step
// - cursor steps after every memory byte
// - cursor write loads low then high byte
// - cursor read returns low then high byte
// - memory write stores bytes until next command
// - memory read returns bytes until next command
// - erase clears from cursor to memory end
// - sleep blanks display and halts activity
// - only system set wakes; memory kept
// - select line and strobes decode bus cycles
`timescale 1ns/10ps
`default_nettype none
`include "lcd_cfg.svh"
module lcd_graphic_command_decoder (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rstn,
  // host bus pins
  input  wire logic             cs_n,
  input  wire logic             rd_n,
  input  wire logic             wr_n,
  input  wire logic             command_data_select,
  input  wire logic [7:0]       host_din,
  output wire logic [7:0]       host_dout,
  output wire logic             host_doe,
  // line pitch for up and down steps
  input  wire logic [15:0]      row_pitch,
  // display configuration
  output wire logic             display_on,
  output wire logic [7:0]       layer_attr,
  output wire lcd_pkg::overlay_s overlay_cfg,
  output wire logic [15:0]      chargen_base,
  output wire lcd_pkg::scroll_s scroll_cfg,
  output wire logic [2:0]       dot_scroll,
  // cursor and activity
  output wire logic [15:0]      cursor_addr,
  output wire logic [1:0]       cursor_dir,
  output wire logic             sleeping,
  output wire logic             busy
);

  typedef struct packed {
    logic                wr_s1, wr_s2, wr_s3;
    logic                rd_s1, rd_s2, rd_s3;
    logic                cs_s1, cs_s2, cs_s3;
    logic                sel_s1, sel_s2, sel_s3;
    logic [7:0]          d_s1, d_s2, d_s3;
    lcd_pkg::dec_state_e state;
    logic [7:0]          cmd;
    logic [3:0]          pidx;
    logic [15:0]         cursor;
    logic [1:0]          dir;
    logic [15:0]         erase_addr;
    logic                disp_on;
    logic [7:0]          attr;
    lcd_pkg::overlay_s   ovl;
    logic [15:0]         cg_base;
    lcd_pkg::scroll_s    scr;
    logic [2:0]          dot;
    logic                rd_pend;
    logic                rd_is_data;
    logic [7:0]          dout;
    logic                doe;
    logic                busy;
    logic                slp;
  } dec_state_s;

  dec_state_s          r;
  dec_state_s          n;
  logic [7:0]          mem [0:`MEM_DEPTH-1];
  logic                mem_we;
  logic [15:0]         mem_addr;
  logic [7:0]          mem_wdata;
  logic                f_push;
  logic                f_in_ready;
  logic                f_out_valid;
  logic [8:0]          f_out_raw;
  logic                f_pop;
  lcd_pkg::host_byte_s hb;
  lcd_pkg::host_byte_s push_byte;
  logic                wr_done;
  logic                rd_start;
  logic                rd_serve;
  logic [7:0]          status;

  // next cursor address for a given step direction
  function automatic logic [15:0] step(input logic [15:0] cur, input logic [1:0] d,
                                       input logic [15:0] pitch);
    logic [15:0] res;
    res = cur;
    case (d)
      2'h0:    res = cur + 16'h0001;
      2'h1:    res = cur - 16'h0001;
      2'h2:    res = cur - pitch;
      2'h3:    res = cur + pitch;
      default: res = cur;
    endcase
    return res;
  endfunction

  // bus strobe edges seen after synchronisation
  assign wr_done   = r.wr_s2 & ~r.wr_s3 & ~r.cs_s3;
  assign rd_start  = ~r.rd_s2 & r.rd_s3 & ~r.cs_s2;
  assign push_byte = '{is_cmd: r.sel_s3, val: r.d_s3};
  assign f_push    = wr_done;
  assign hb        = lcd_pkg::host_byte_s'(f_out_raw);
  assign f_pop     = f_out_valid & (r.state != lcd_pkg::ST_ERASE);
  // status reads answer at once so busy can be polled during erase
  assign rd_serve  = r.rd_pend & (~r.rd_is_data |
                     (~f_out_valid & (r.state != lcd_pkg::ST_ERASE)));

  // status byte: busy while erasing or the fifo is full
  always_comb begin
    status = 8'h00;
    status[`STAT_BUSY_BIT]  = r.busy;
    status[`STAT_SLEEP_BIT] = (r.state == lcd_pkg::ST_SLEEP);
  end

  // host writes wait here while the decoder is erasing
  byte_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rstn      (rstn),
    .in_valid  (f_push),
    .in_data   (push_byte),
    .in_ready  (f_in_ready),
    .out_valid (f_out_valid),
    .out_data  (f_out_raw),
    .out_ready (f_pop)
  );

  // decoder next state
  always_comb begin
    n         = r;
    mem_we    = 1'b0;
    mem_addr  = r.cursor;
    mem_wdata = 8'h00;
    // pin synchronisers plus one stage for edges
    n.wr_s1 = wr_n;
    n.wr_s2 = r.wr_s1;
    n.wr_s3 = r.wr_s2;
    n.rd_s1 = rd_n;
    n.rd_s2 = r.rd_s1;
    n.rd_s3 = r.rd_s2;
    n.cs_s1 = cs_n;
    n.cs_s2 = r.cs_s1;
    n.cs_s3 = r.cs_s2;
    n.sel_s1 = command_data_select;
    n.sel_s2 = r.sel_s1;
    n.sel_s3 = r.sel_s2;
    n.d_s1  = host_din;
    n.d_s2  = r.d_s1;
    n.d_s3  = r.d_s2;
    n.doe   = ~r.rd_s2 & ~r.cs_s2;
    n.busy  = ~f_in_ready | (r.state == lcd_pkg::ST_ERASE);
    // one byte cleared per cycle until the top of memory
    if (r.state == lcd_pkg::ST_ERASE) begin
      mem_we    = 1'b1;
      mem_addr  = r.erase_addr;
      mem_wdata = 8'h00;
      if (r.erase_addr == `MEM_TOP) begin
        n.state = lcd_pkg::ST_RUN;
      end else begin
        n.erase_addr = r.erase_addr + 16'h0001;
      end
    end
    // command bytes
    if (f_pop && hb.is_cmd) begin
      if (r.state != lcd_pkg::ST_SLEEP || hb.val == `CMD_SYSTEM_SET) begin
        n.cmd  = hb.val;
        n.pidx = 4'h0;
        case (hb.val)
          `CMD_SYSTEM_SET: n.state = lcd_pkg::ST_RUN;
          `CMD_DISPLAY_OFF: n.disp_on = 1'b0;
          `CMD_DISPLAY_ON: n.disp_on = 1'b1;
          `CMD_CURSOR_RIGHT, `CMD_CURSOR_LEFT,
          `CMD_CURSOR_UP, `CMD_CURSOR_DOWN: n.dir = hb.val[1:0];
          `CMD_ERASE: begin
            n.state      = lcd_pkg::ST_ERASE;
            n.erase_addr = r.cursor;
          end
          `CMD_SLEEP: begin
            n.state   = lcd_pkg::ST_SLEEP;
            n.disp_on = 1'b0;
          end
          default: n.cmd = hb.val;
        endcase
      end
    end
    // parameter and data bytes
    if (f_pop && !hb.is_cmd && r.state == lcd_pkg::ST_RUN) begin
      if (r.pidx != 4'hf) begin
        n.pidx = r.pidx + 4'h1;
      end
      case (r.cmd)
        `CMD_DISPLAY_OFF, `CMD_DISPLAY_ON: begin
          if (r.pidx == 4'h0) n.attr = hb.val;
        end
        `CMD_OVERLAY: begin
          if (r.pidx == 4'h0) n.ovl = lcd_pkg::overlay_s'(hb.val);
        end
        `CMD_CHARGEN_ADDR: begin
          if (r.pidx == 4'h0) n.cg_base[7:0] = hb.val;
          if (r.pidx == 4'h1) n.cg_base[15:8] = hb.val;
        end
        `CMD_SCROLL: begin
          case (r.pidx)
            4'h0:    n.scr.layer_one_start[7:0]    = hb.val;
            4'h1:    n.scr.layer_one_start[15:8]   = hb.val;
            4'h2:    n.scr.layer_one_lines         = hb.val;
            4'h3:    n.scr.layer_two_start[7:0]    = hb.val;
            4'h4:    n.scr.layer_two_start[15:8]   = hb.val;
            4'h5:    n.scr.layer_two_lines         = hb.val;
            4'h6:    n.scr.layer_three_start[7:0]  = hb.val;
            4'h7:    n.scr.layer_three_start[15:8] = hb.val;
            default: n.scr = r.scr;
          endcase
        end
        `CMD_DOT_SCROLL: begin
          if (r.pidx == 4'h0) n.dot = hb.val[2:0];
        end
        `CMD_CURSOR_WRITE: begin
          if (r.pidx == 4'h0) n.cursor[7:0] = hb.val;
          if (r.pidx == 4'h1) n.cursor[15:8] = hb.val;
        end
        `CMD_MEM_WRITE: begin
          mem_we    = 1'b1;
          mem_addr  = r.cursor;
          mem_wdata = hb.val;
          n.cursor  = step(r.cursor, r.dir, row_pitch);
        end
        default: n.pidx = r.pidx;
      endcase
    end
    // reads are caught at the falling strobe; data reads are answered once writes drain, status reads at once
    if (rd_start) begin
      n.rd_pend    = 1'b1;
      n.rd_is_data = r.sel_s2;
    end
    if (rd_serve) begin
      n.rd_pend = 1'b0;
      n.dout    = 8'h00;
      if (!r.rd_is_data) begin
        n.dout = status;
      end else if (r.state == lcd_pkg::ST_RUN) begin
        case (r.cmd)
          `CMD_CURSOR_READ: begin
            n.dout = (r.pidx == 4'h0) ? r.cursor[7:0] : r.cursor[15:8];
            if (r.pidx != 4'hf) n.pidx = r.pidx + 4'h1;
          end
          `CMD_MEM_READ: begin
            n.dout   = mem[r.cursor[14:0]];
            n.cursor = step(r.cursor, r.dir, row_pitch);
          end
          default: n.dout = 8'h00;
        endcase
      end
    end
    // registered copy of the sleep state for the output pin
    n.slp = (n.state == lcd_pkg::ST_SLEEP);
  end

  // state register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      r            <= '0;
      r.wr_s1      <= 1'b1;
      r.wr_s2      <= 1'b1;
      r.wr_s3      <= 1'b1;
      r.rd_s1      <= 1'b1;
      r.rd_s2      <= 1'b1;
      r.rd_s3      <= 1'b1;
      r.cs_s1      <= 1'b1;
      r.cs_s2      <= 1'b1;
      r.cs_s3      <= 1'b1;
      r.state      <= lcd_pkg::ST_RUN;
      r.cmd        <= `RST_CMD;
      r.cursor     <= `RST_CURSOR;
      r.attr       <= `RST_LAYER_ATTR;
      r.ovl        <= lcd_pkg::overlay_s'(`RST_OVERLAY);
      r.cg_base    <= `RST_ADDR;
      r.scr        <= '{`RST_ADDR, `RST_LINES, `RST_ADDR, `RST_LINES, `RST_ADDR};
      r.dot        <= `RST_DOT_SCROLL;
    end else begin
      r <= n;
    end
  end

  // display memory, untouched while asleep
  always_ff @(posedge mclk) begin
    if (mem_we) begin
      mem[mem_addr[14:0]] <= mem_wdata;
    end
  end

  // outputs straight from the state register
  assign host_dout    = r.dout;
  assign host_doe     = r.doe;
  assign display_on   = r.disp_on;
  assign layer_attr   = r.attr;
  assign overlay_cfg  = r.ovl;
  assign chargen_base = r.cg_base;
  assign scroll_cfg   = r.scr;
  assign dot_scroll   = r.dot;
  assign cursor_addr  = r.cursor;
  assign cursor_dir   = r.dir;
  assign sleeping     = r.slp;
  assign busy         = r.busy;

  // checks on decoder behaviour
  a_erase_zero: assert property (@(posedge mclk) disable iff (!rstn)
    (r.state == lcd_pkg::ST_ERASE) |-> (mem_we && mem_wdata == 8'h00))
    else $error("erase did not write zero");
  a_erase_done: assert property (@(posedge mclk) disable iff (!rstn)
    (r.state == lcd_pkg::ST_ERASE && r.erase_addr == `MEM_TOP) |=> (r.state == lcd_pkg::ST_RUN))
    else $error("erase did not stop at memory top");
  a_sleep_keeps_mem: assert property (@(posedge mclk) disable iff (!rstn)
    (r.state == lcd_pkg::ST_SLEEP) |-> !mem_we)
    else $error("memory written while asleep");
  a_sleep_entry: assert property (@(posedge mclk) disable iff (!rstn)
    (f_pop && hb.is_cmd && hb.val == `CMD_SLEEP && r.state == lcd_pkg::ST_RUN)
    |=> (r.state == lcd_pkg::ST_SLEEP && !r.disp_on))
    else $error("sleep did not blank and halt");
  a_wake_only_sysset: assert property (@(posedge mclk) disable iff (!rstn)
    (r.state == lcd_pkg::ST_SLEEP && !(f_pop && hb.is_cmd && hb.val == `CMD_SYSTEM_SET))
    |=> (r.state == lcd_pkg::ST_SLEEP))
    else $error("left sleep without system set");
  a_write_step: assert property (@(posedge mclk) disable iff (!rstn)
    (f_pop && !hb.is_cmd && r.state == lcd_pkg::ST_RUN && r.cmd == `CMD_MEM_WRITE)
    |=> (r.cursor == step($past(r.cursor), $past(r.dir), $past(row_pitch))))
    else $error("cursor did not step after write");
  a_cursor_high: assert property (@(posedge mclk) disable iff (!rstn)
    (f_pop && !hb.is_cmd && r.state == lcd_pkg::ST_RUN && r.cmd == `CMD_CURSOR_WRITE
     && r.pidx == 4'h1) |=> (r.cursor[15:8] == $past(hb.val)))
    else $error("cursor high byte not loaded");
  a_cmd_restart: assert property (@(posedge mclk) disable iff (!rstn)
    (f_pop && hb.is_cmd && r.state == lcd_pkg::ST_RUN) |=> (r.pidx == 4'h0 && r.cmd == $past(hb.val)))
    else $error("command did not restart parameters");
  a_dir_select: assert property (@(posedge mclk) disable iff (!rstn)
    (f_pop && hb.is_cmd && r.state == lcd_pkg::ST_RUN && hb.val[7:2] == 6'h13)
    |=> (r.dir == $past(hb.val[1:0])))
    else $error("cursor direction not taken");
  a_disp_off: assert property (@(posedge mclk) disable iff (!rstn)
    (f_pop && hb.is_cmd && r.state == lcd_pkg::ST_RUN && hb.val == `CMD_DISPLAY_OFF)
    |=> !r.disp_on)
    else $error("display off ignored");
  a_status_read: assert property (@(posedge mclk) disable iff (!rstn)
    (rd_serve && !r.rd_is_data) |=> (r.dout == $past(status)))
    else $error("status read returned wrong byte");
endmodule
`default_nettype wire

// File: lcd_host_model.sv
// behavioural host processor driving the decoder's parallel bus
`timescale 1ns/10ps
`default_nettype none
module lcd_host_model (
  // clock
  input  wire logic       mclk,
  // bus strobes and select
  output var  logic       cs_n,
  output var  logic       rd_n,
  output var  logic       wr_n,
  output var  logic       command_data_select,
  // data bus
  output var  logic [7:0] host_din,
  input  wire logic [7:0] host_dout,
  input  wire logic       host_doe
);
  // bus idles deselected, data shows no stale byte
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    command_data_select = 1'b0;
    host_din = 8'h5a;
  end

  // one write cycle: select 1 = command, 0 = parameter; no ready poll needed
  task automatic wr(input logic sel, input logic [7:0] d);
    @(posedge mclk);
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    command_data_select <= sel;
    host_din <= d;
    repeat (12) @(posedge mclk);
    wr_n <= 1'b1;
    repeat (4) @(posedge mclk);
    cs_n <= 1'b1;
    host_din <= ~d; // released bus no longer shows the byte
    repeat (8) @(posedge mclk);
  endtask

  // one read cycle: select 0 = status, 1 = data
  task automatic rd(input logic sel, output logic [7:0] d, output logic oe);
    @(posedge mclk);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    command_data_select <= sel;
    repeat (24) @(posedge mclk);
    d = host_dout;
    oe = host_doe;
    rd_n <= 1'b1;
    cs_n <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// File: lcd_graphic_command_decoder_test.sv
// self-checking testbench of the display command decoder
`timescale 1ns/10ps
`default_nettype none
`include "lcd_cfg.svh"
module lcd_graphic_command_decoder_test;
  logic              mclk;
  logic              rstn;
  logic              cs_n;
  logic              rd_n;
  logic              wr_n;
  logic              cmd_sel;
  logic [7:0]        host_din;
  logic [7:0]        host_dout;
  logic [7:0]        layer_attr;
  logic [7:0]        rdata;
  logic              host_doe;
  logic              display_on;
  logic              sleeping;
  logic              busy;
  logic              oe;
  logic              saw_busy;
  logic [15:0]       row_pitch;
  logic [15:0]       chargen_base;
  logic [15:0]       cursor_addr;
  logic [15:0]       exp16;
  logic [2:0]        dot_scroll;
  logic [1:0]        cursor_dir;
  lcd_pkg::overlay_s overlay_cfg;
  lcd_pkg::scroll_s  scroll_cfg;
  int                n_errors = 0;
  int                check_count = 0;

  // host model stands on the bus side
  lcd_host_model i_host (.mclk(mclk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .command_data_select(cmd_sel), .host_din(host_din), .host_dout(host_dout),
    .host_doe(host_doe));

  // decoder under test
  lcd_graphic_command_decoder i_dut (.mclk(mclk), .rstn(rstn), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .command_data_select(cmd_sel), .host_din(host_din), .host_dout(host_dout),
    .host_doe(host_doe), .row_pitch(row_pitch), .display_on(display_on),
    .layer_attr(layer_attr), .overlay_cfg(overlay_cfg), .chargen_base(chargen_base),
    .scroll_cfg(scroll_cfg), .dot_scroll(dot_scroll), .cursor_addr(cursor_addr),
    .cursor_dir(cursor_dir), .sleeping(sleeping), .busy(busy));

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // value comparison
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // verdict and end of run
  task automatic finish_test();
    if (n_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // bus access shorthands
  task automatic cmd(input logic [7:0] c);
    i_host.wr(1'b1, c);
  endtask
  task automatic par(input logic [7:0] p);
    i_host.wr(1'b0, p);
  endtask
  task automatic setcur(input logic [15:0] a);
    cmd(`CMD_CURSOR_WRITE);
    par(a[7:0]);
    par(a[15:8]);
  endtask
  task automatic memrd(output logic [7:0] d);
    i_host.rd(1'b1, d, oe);
  endtask

  // hang guard
  initial begin
    repeat (40000) @(posedge mclk);
    n_errors++;
    finish_test();
  end

  // test sequence
  initial begin
    rstn = 1'b0;
    row_pitch = 16'h0028;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    repeat (4) @(posedge mclk);
    chk("cursor_addr", 64'h0, cursor_addr);
    chk("display_on", 64'h0, display_on);
    chk("host_doe", 64'h0, host_doe);
    // display on then off, attribute byte kept
    cmd(`CMD_DISPLAY_ON);
    par(8'h15);
    chk("display_on", 64'h1, display_on);
    cmd(`CMD_DISPLAY_OFF);
    par(8'h05);
    chk("display_on", 64'h0, display_on);
    chk("layer_attr", 64'h05, layer_attr);
    // every combine method with layer kinds and count
    for (int m = 0; m < 4; m++) begin
      cmd(`CMD_OVERLAY);
      par(8'h14 | 8'(m));
      chk("overlay_cfg", 64'h14 | 64'(m), overlay_cfg);
    end
    // pattern table base leaves room for an 8K block below memory top
    cmd(`CMD_CHARGEN_ADDR);
    par(8'h00);
    par(8'h60);
    chk("chargen_base", 64'h6000, chargen_base);
    cmd(`CMD_SCROLL);
    for (int i = 0; i < 8; i++) par(8'(8'h11 * (i + 1)));
    chk("scroll_cfg", 64'h2211335544668877, scroll_cfg);
    cmd(`CMD_DOT_SCROLL);
    par(8'hfd);
    chk("dot_scroll", 64'h5, dot_scroll);
    // half-sent cursor write cut short by a new command
    cmd(`CMD_CURSOR_WRITE);
    par(8'h99);
    cmd(`CMD_DOT_SCROLL);
    par(8'h02);
    chk("dot_scroll", 64'h2, dot_scroll);
    // each direction, one byte written, cursor step checked
    for (int i = 0; i < 4; i++) begin
      setcur(16'h0200);
      chk("cursor_addr", 64'h0200, cursor_addr);
      cmd(8'(`CMD_CURSOR_RIGHT + i));
      chk("cursor_dir", 64'(i), cursor_dir);
      cmd(`CMD_MEM_WRITE);
      par(8'h3c);
      case (i)
        0: exp16 = 16'h0201;
        1: exp16 = 16'h01ff;
        2: exp16 = 16'h0200 - row_pitch;
        default: exp16 = 16'h0200 + row_pitch;
      endcase
      chk("cursor_addr", 64'(exp16), cursor_addr);
    end
    // streamed write then streamed read back
    cmd(`CMD_CURSOR_RIGHT);
    setcur(16'h0100);
    cmd(`CMD_MEM_WRITE);
    par(8'ha5);
    par(8'h5a);
    setcur(16'h0100);
    cmd(`CMD_MEM_READ);
    memrd(rdata);
    chk("mem_read", 64'ha5, rdata);
    chk("host_doe", 64'h1, oe);
    memrd(rdata);
    chk("mem_read", 64'h5a, rdata);
    chk("cursor_addr", 64'h0102, cursor_addr);
    // cursor read, low byte then high byte
    setcur(16'h1234);
    cmd(`CMD_CURSOR_READ);
    memrd(rdata);
    chk("cursor_low", 64'h34, rdata);
    memrd(rdata);
    chk("cursor_high", 64'h12, rdata);
    // erase from 7f00 up, with a marked byte inside the range
    setcur(16'h7ff8);
    cmd(`CMD_MEM_WRITE);
    par(8'h77);
    setcur(16'h7f00);
    cmd(`CMD_ERASE);
    saw_busy = 1'b0;
    // host polls busy before any further command
    for (int k = 0; k < 50; k++) begin
      i_host.rd(1'b0, rdata, oe);
      if (rdata[`STAT_BUSY_BIT] === 1'b1) saw_busy = 1'b1;
      if (rdata[`STAT_BUSY_BIT] === 1'b0) break;
    end
    chk("erase_busy", 64'h1, saw_busy);
    chk("status", 64'h0, rdata);
    chk("cursor_addr", 64'h7f00, cursor_addr);
    setcur(16'h7ff8);
    cmd(`CMD_MEM_READ);
    memrd(rdata);
    chk("erased_byte", 64'h00, rdata);
    // sleep ignores other commands until system set
    cmd(`CMD_DISPLAY_ON);
    par(8'h15);
    cmd(`CMD_SLEEP);
    chk("sleeping", 64'h1, sleeping);
    chk("display_on", 64'h0, display_on);
    setcur(16'h0100);
    chk("cursor_addr", 64'h7ff9, cursor_addr);
    i_host.rd(1'b0, rdata, oe);
    chk("status", 64'h01, rdata);
    cmd(`CMD_SYSTEM_SET);
    chk("sleeping", 64'h0, sleeping);
    setcur(16'h0100);
    cmd(`CMD_MEM_READ);
    memrd(rdata);
    chk("kept_byte", 64'ha5, rdata);
    finish_test();
  end
endmodule
`default_nettype wire
